// ---- design/sfc_pkg.sv ----
// Purpose: Shared constants and types for one synchronous FIFO channel
// Assumes: One system clock samples every channel pin
// Notes: The offset load order is also the readback order
package sfc_pkg;

	// ----------------------------------------------------------------
	// Widths and default sizes
	// ----------------------------------------------------------------
	localparam int unsigned DATA_W = 9;
	localparam int unsigned OFS_W = 8;
	localparam int unsigned DEPTH_DEF = 256;
	localparam int unsigned STAGE_DEPTH_DEF = 8;

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [OFS_W-1:0] EMPTY_LO_RST = 8'h07;
	localparam logic [OFS_W-1:0] EMPTY_HI_RST = 8'h00;
	localparam logic [OFS_W-1:0] FULL_LO_RST = 8'h07;
	localparam logic [OFS_W-1:0] FULL_HI_RST = 8'h00;
	localparam logic [DATA_W-1:0] OUT_RST = 9'h000;
	localparam logic FULL_N_RST = 1'h1;
	localparam logic AFULL_N_RST = 1'h1;
	localparam logic EMPTY_N_RST = 1'h0;
	localparam logic AEMPTY_N_RST = 1'h0;

	// ----------------------------------------------------------------
	// Offset register positions and sequence
	// ----------------------------------------------------------------
	localparam logic [1:0] IDX_EMPTY_LO = 2'h0;
	localparam logic [1:0] IDX_EMPTY_HI = 2'h1;
	localparam logic [1:0] IDX_FULL_LO = 2'h2;
	localparam logic [1:0] IDX_FULL_HI = 2'h3;

	typedef enum logic [3:0] {
		OFS_EMPTY_LO = 4'h1,
		OFS_EMPTY_HI = 4'h2,
		OFS_FULL_LO = 4'h4,
		OFS_FULL_HI = 4'h8
	} sfc_ofs_sel_type;

	function automatic sfc_ofs_sel_type sfc_ofs_next(input sfc_ofs_sel_type s);
		unique case (s)
			OFS_EMPTY_LO: sfc_ofs_next = OFS_EMPTY_HI;
			OFS_EMPTY_HI: sfc_ofs_next = OFS_FULL_LO;
			OFS_FULL_LO: sfc_ofs_next = OFS_FULL_HI;
			default: sfc_ofs_next = OFS_EMPTY_LO;
		endcase
	endfunction : sfc_ofs_next

	function automatic logic [1:0] sfc_ofs_idx(input sfc_ofs_sel_type s);
		unique case (s)
			OFS_EMPTY_HI: sfc_ofs_idx = IDX_EMPTY_HI;
			OFS_FULL_LO: sfc_ofs_idx = IDX_FULL_LO;
			OFS_FULL_HI: sfc_ofs_idx = IDX_FULL_HI;
			default: sfc_ofs_idx = IDX_EMPTY_LO;
		endcase
	endfunction : sfc_ofs_idx

endpackage : sfc_pkg

// ---- design/sfc_channel.sv ----
// Purpose: One channel of a dual synchronous FIFO with programmable flags
// Assumes: Pin clocks are slow enough to be sampled by SYS_CLK_I
// Notes: Pin data must hold two system cycles past each pin clock rise
// Contract
// R1: Reset returns read and write pointers to the first location.
// R2: Writer must reset the channel after power-up before any write.
// R3: Reset drives full and almost-full high, empty and almost-empty low.
// R4: Reset clears the output register and loads default offsets.
// R5: Writes start on write clock rise; full flags update on that edge.
// R6: Works with asynchronous or identical write and read clocks.
// R7: Flag mode: first write enable low stores a word each write edge.
// R8: Flag mode: first write enable high holds input, stores nothing.
// R9: Full drives full flag low, writes ignored; a read releases it.
// R10: Both read enables low moves next word to output on read edge.
// R11: Either read enable high holds the output register.
// R12: Empty drives empty flag low, reads ignored; a write releases it.
// R13: Empty and almost-empty flags update on read clock rise.
// R14: Output enable low drives data out; high floats the data outputs.
// R15: Dual pin sampled in reset: high two enables, low load strobe.
// R16: Two-enable mode stores only with first low and second high.
// R17: Two-enable mode otherwise holds input; enables ignored when full.
// R18: Four 8-bit offset registers, loaded from inputs, read on outputs.
// R19: Loads step empty low, empty high, full low, full high, wrap.
// R20: Load position kept while strobe high; next load continues.
// R21: Strobe and read enables low step offsets out in load order.
// R22: Almost-empty low while n or fewer words held, n empty offset.
// R23: Almost-full low at depth minus m words or more, m full offset.
// R24: Controller avoids loading and reading back offsets together.
// R25: Depth is a power-of-two parameter; offsets truncated to address.
// R26: Flags never release falsely and no word is lost.
`timescale 1ns/1ps

// ------------------------------------------------------------------------
// Staging buffer between write capture and the main array
// ------------------------------------------------------------------------
module sfc_stage_fifo #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW:0] wp_q;
	logic [PW:0] rp_q;
	logic push;
	logic pop;

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("Stage depth must be a power of two of at least two");
	end

	// Extra pointer bit tells full from empty
	assign out_valid_o = (wp_q != rp_q);
	assign in_ready_o = (wp_q != {~rp_q[PW], rp_q[PW-1:0]});
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	assign out_data_o = mem_q[rp_q[PW-1:0]];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_q[wp_q[PW-1:0]] <= in_data_i;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'h1;
			end
			if (pop) begin
				rp_q <= rp_q + 1'h1;
			end
		end
	end

endmodule : sfc_stage_fifo

// ------------------------------------------------------------------------
// Channel top
// ------------------------------------------------------------------------
module sfc_channel
	import sfc_pkg::*;
#(
	parameter int unsigned DEPTH = DEPTH_DEF,
	parameter int unsigned STAGE_DEPTH = STAGE_DEPTH_DEF
) (
	// System
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// Write port pins
	input wire logic WRITE_CLOCK_I,
	input wire logic WRITE_ENABLE_FIRST_N_I,
	input wire logic WRITE_ENABLE_SECOND_OR_LOAD_I,
	input wire logic [DATA_W-1:0] WRITE_DATA_I,
	// Read port pins
	input wire logic READ_CLOCK_I,
	input wire logic READ_ENABLE_FIRST_N_I,
	input wire logic READ_ENABLE_SECOND_N_I,
	input wire logic OUTPUT_ENABLE_N_I,
	output logic [DATA_W-1:0] READ_DATA_O,
	output logic READ_DATA_OE_O,
	// Flags
	output logic FULL_N_O,
	output logic ALMOST_FULL_N_O,
	output logic EMPTY_N_O,
	output logic ALMOST_EMPTY_N_O
);
	localparam int unsigned AW = $clog2(DEPTH);
	localparam int unsigned PIN_W = DATA_W + 7;
	localparam logic [AW:0] DEPTH_L = (AW+1)'(DEPTH);

	if (DEPTH < 16 || DEPTH > 65536 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
		$error("Depth must be a power of two from 16 to 65536");
	end

	// ----------------------------------------------------------------
	// Reset and pin synchronisers
	// ----------------------------------------------------------------
	logic rst_m_q;
	logic rst_q;
	logic [PIN_W-1:0] pin_m_q;
	logic [PIN_W-1:0] pin_s_q;
	logic wclk_s, wen1_n_s, wen2_s, rclk_s, ren1_n_s, ren2_n_s, oe_n_s;
	logic [DATA_W-1:0] wdata_s;
	logic wclk_d_q;
	logic rclk_d_q;
	logic wr_edge;
	logic rd_edge;

	// Release is synchronous so no flop sees a runt reset edge
	always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rst_m_q <= 1'h1;
			rst_q <= 1'h1;
		end else begin
			rst_m_q <= 1'h0;
			rst_q <= rst_m_q;
		end
	end

	// Pins share one pipe so data lines up with its clock edge
	always_ff @(posedge SYS_CLK_I) begin
		pin_m_q <= {WRITE_CLOCK_I, WRITE_ENABLE_FIRST_N_I, WRITE_ENABLE_SECOND_OR_LOAD_I,
			WRITE_DATA_I, READ_CLOCK_I, READ_ENABLE_FIRST_N_I, READ_ENABLE_SECOND_N_I,
			OUTPUT_ENABLE_N_I};
		pin_s_q <= pin_m_q;
	end

	assign {wclk_s, wen1_n_s, wen2_s, wdata_s, rclk_s, ren1_n_s, ren2_n_s, oe_n_s} = pin_s_q;

	always_ff @(posedge SYS_CLK_I) begin
		wclk_d_q <= wclk_s;
		rclk_d_q <= rclk_s;
	end

	// Each pin clock gets its own edge, so tied or free clocks both work
	assign wr_edge = wclk_s && !wclk_d_q && !rst_q; // R5 R6
	assign rd_edge = rclk_s && !rclk_d_q && !rst_q; // R6

	// ----------------------------------------------------------------
	// Mode capture
	// ----------------------------------------------------------------
	logic mode_two_q;

	// Not reset: it must follow the pin for the whole reset pulse
	always_ff @(posedge SYS_CLK_I) begin
		if (rst_q) begin
			mode_two_q <= wen2_s; // R15 R2
		end
	end

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	logic full_n_q;
	logic afull_n_q;
	logic empty_n_q;
	logic aempty_n_q;
	logic wr_cmd;
	logic wr_take;
	logic ofs_load;
	logic rd_both;
	logic ofs_read;
	logic rd_take;
	logic stg_in_ready;
	logic stg_out_valid;
	logic [DATA_W-1:0] stg_data;
	logic arr_room;
	logic drain;

	// Same pin pattern writes in both modes; only flag mode loads offsets
	assign wr_cmd = wr_edge && !wen1_n_s && wen2_s && full_n_q; // R7 R8 R16 R17 R9
	assign wr_take = wr_cmd && stg_in_ready;
	assign ofs_load = wr_edge && !wen1_n_s && !wen2_s && !mode_two_q; // R19 R20
	assign rd_both = rd_edge && !ren1_n_s && !ren2_n_s; // R10 R11
	assign ofs_read = rd_both && !mode_two_q && !wen2_s; // R21
	assign rd_take = rd_both && !ofs_read && empty_n_q; // R12

	sfc_stage_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(STAGE_DEPTH)
	) u_stage (
		.clk_i(SYS_CLK_I),
		.rst_i(rst_q),
		.in_valid_i(wr_cmd),
		.in_ready_o(stg_in_ready),
		.in_data_i(wdata_s),
		.out_valid_o(stg_out_valid),
		.out_ready_i(arr_room),
		.out_data_o(stg_data)
	);

	// ----------------------------------------------------------------
	// Main array and counts
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [AW:0] arr_cnt_q;
	logic [AW:0] level_q;
	logic [AW:0] arr_d;
	logic [AW:0] lvl_d;
	logic [DATA_W-1:0] rd_word;

	assign arr_room = (arr_cnt_q != DEPTH_L);
	assign drain = stg_out_valid && arr_room;
	assign rd_word = mem_q[rd_ptr_q];

	always_ff @(posedge SYS_CLK_I) begin
		if (drain) begin
			mem_q[wr_ptr_q] <= stg_data;
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge rst_q) begin
		if (rst_q) begin
			wr_ptr_q <= '0; // R1
			rd_ptr_q <= '0; // R1
		end else begin
			if (drain) begin
				wr_ptr_q <= wr_ptr_q + 1'h1;
			end
			if (rd_take) begin
				rd_ptr_q <= rd_ptr_q + 1'h1;
			end
		end
	end

	// Level counts staged words too, so full never lets a word slip
	always_comb begin
		arr_d = arr_cnt_q;
		lvl_d = level_q;
		if (drain) begin
			arr_d = arr_d + 1'h1;
		end
		if (rd_take) begin
			arr_d = arr_d - 1'h1;
			lvl_d = lvl_d - 1'h1;
		end
		if (wr_take) begin
			lvl_d = lvl_d + 1'h1; // R26
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge rst_q) begin
		if (rst_q) begin
			arr_cnt_q <= '0;
			level_q <= '0;
		end else begin
			arr_cnt_q <= arr_d;
			level_q <= lvl_d;
		end
	end

	// ----------------------------------------------------------------
	// Offset registers
	// ----------------------------------------------------------------
	logic [OFS_W-1:0] ofs_q [4];
	sfc_ofs_sel_type wsel_q;
	sfc_ofs_sel_type rsel_q;
	logic [2*OFS_W-1:0] e_ofs16;
	logic [2*OFS_W-1:0] f_ofs16;
	logic [AW:0] e_ofs_x;
	logic [AW:0] f_ofs_x;
	logic [OFS_W-1:0] ofs_rd_byte;

	assign e_ofs16 = {ofs_q[IDX_EMPTY_HI], ofs_q[IDX_EMPTY_LO]};
	assign f_ofs16 = {ofs_q[IDX_FULL_HI], ofs_q[IDX_FULL_LO]};
	// Bits above the address width are dropped
	assign e_ofs_x = {1'h0, e_ofs16[AW-1:0]}; // R25
	assign f_ofs_x = {1'h0, f_ofs16[AW-1:0]}; // R25
	assign ofs_rd_byte = ofs_q[sfc_ofs_idx(rsel_q)];

	always_ff @(posedge SYS_CLK_I or posedge rst_q) begin
		if (rst_q) begin
			ofs_q[IDX_EMPTY_LO] <= EMPTY_LO_RST; // R4
			ofs_q[IDX_EMPTY_HI] <= EMPTY_HI_RST;
			ofs_q[IDX_FULL_LO] <= FULL_LO_RST;
			ofs_q[IDX_FULL_HI] <= FULL_HI_RST;
		end else if (ofs_load) begin
			ofs_q[sfc_ofs_idx(wsel_q)] <= wdata_s[OFS_W-1:0]; // R18
		end
	end

	// Position survives the strobe going high
	always_ff @(posedge SYS_CLK_I or posedge rst_q) begin
		if (rst_q) begin
			wsel_q <= OFS_EMPTY_LO;
		end else if (ofs_load) begin
			wsel_q <= sfc_ofs_next(wsel_q); // R19 R20
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge rst_q) begin
		if (rst_q) begin
			rsel_q <= OFS_EMPTY_LO;
		end else if (ofs_read) begin
			rsel_q <= sfc_ofs_next(rsel_q); // R21
		end
	end

	// ----------------------------------------------------------------
	// Flags
	// ----------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or posedge rst_q) begin
		if (rst_q) begin
			full_n_q <= FULL_N_RST; // R3
			afull_n_q <= AFULL_N_RST;
		end else if (wr_edge) begin
			full_n_q <= (lvl_d != DEPTH_L); // R5 R9
			afull_n_q <= (lvl_d < DEPTH_L - f_ofs_x); // R23
		end
	end

	// Flag is what gates reads, so a late word cannot be read early
	always_ff @(posedge SYS_CLK_I or posedge rst_q) begin
		if (rst_q) begin
			empty_n_q <= EMPTY_N_RST; // R3
			aempty_n_q <= AEMPTY_N_RST;
		end else if (rd_edge) begin
			empty_n_q <= (arr_d != '0); // R13 R12
			aempty_n_q <= (arr_d > e_ofs_x); // R22
		end
	end

	assign FULL_N_O = full_n_q;
	assign ALMOST_FULL_N_O = afull_n_q;
	assign EMPTY_N_O = empty_n_q;
	assign ALMOST_EMPTY_N_O = aempty_n_q;

	// ----------------------------------------------------------------
	// Output register and enable
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] out_q;

	always_ff @(posedge SYS_CLK_I or posedge rst_q) begin
		if (rst_q) begin
			out_q <= OUT_RST; // R4
		end else if (ofs_read) begin
			out_q <= {{(DATA_W-OFS_W){1'h0}}, ofs_rd_byte}; // R21
		end else if (rd_take) begin
			out_q <= rd_word; // R10
		end
	end

	assign READ_DATA_O = out_q;
	assign READ_DATA_OE_O = !oe_n_s; // R14

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_wr_take;
		wr_edge && !wen1_n_s && wen2_s && full_n_q && stg_in_ready;
	endsequence

	sequence s_rd_take;
		rd_edge && !ren1_n_s && !ren2_n_s && empty_n_q && !ofs_read;
	endsequence

	property p_ptr_reset;
		@(posedge SYS_CLK_I) rst_q |-> (wr_ptr_q == '0 && rd_ptr_q == '0 && level_q == '0);
	endproperty
	a_ptr_reset: assert property (p_ptr_reset) else $error("Pointers not cleared"); // R1

	property p_reset_flags;
		@(posedge SYS_CLK_I) rst_q |-> (FULL_N_O && ALMOST_FULL_N_O && !EMPTY_N_O
			&& !ALMOST_EMPTY_N_O);
	endproperty
	a_reset_flags: assert property (p_reset_flags) else $error("Bad reset flags"); // R3

	property p_reset_regs;
		@(posedge SYS_CLK_I) rst_q |-> (out_q == OUT_RST && ofs_q[IDX_EMPTY_LO] == EMPTY_LO_RST
			&& ofs_q[IDX_FULL_HI] == FULL_HI_RST);
	endproperty
	a_reset_regs: assert property (p_reset_regs) else $error("Bad reset registers"); // R4

	property p_mode_sample;
		// Pin pipe holds no reset, so the first two reset cycles see no pin level
		@(posedge SYS_CLK_I) (rst_q && $past(rst_q, 2)) |=> mode_two_q == $past(wen2_s);
	endproperty
	a_mode_sample: assert property (p_mode_sample) else $error("Mode not sampled"); // R15

	property p_full_flag;
		@(posedge SYS_CLK_I) disable iff (rst_q)
		wr_edge |=> (FULL_N_O == (level_q != DEPTH_L));
	endproperty
	a_full_flag: assert property (p_full_flag) else $error("Full flag wrong"); // R5

	property p_no_overflow;
		@(posedge SYS_CLK_I) disable iff (rst_q) level_q <= DEPTH_L && arr_cnt_q <= level_q;
	endproperty
	a_no_overflow: assert property (p_no_overflow) else $error("Level overflow"); // R26

	property p_full_refused;
		@(posedge SYS_CLK_I) disable iff (rst_q)
		(wr_edge && !full_n_q) |=> level_q <= $past(level_q);
	endproperty
	a_full_refused: assert property (p_full_refused) else $error("Write while full"); // R9

	property p_write_store;
		@(posedge SYS_CLK_I) disable iff (rst_q)
		(s_wr_take and !rd_take) |=> level_q == $past(level_q) + 1'h1;
	endproperty
	a_write_store: assert property (p_write_store) else $error("Write lost"); // R7

	property p_write_hold;
		@(posedge SYS_CLK_I) disable iff (rst_q)
		(wr_edge && (wen1_n_s || (mode_two_q && !wen2_s))) |=> level_q <= $past(level_q);
	endproperty
	a_write_hold: assert property (p_write_hold) else $error("Write not held"); // R17

	property p_read_load;
		@(posedge SYS_CLK_I) disable iff (rst_q) s_rd_take |=> out_q == $past(rd_word);
	endproperty
	a_read_load: assert property (p_read_load) else $error("Read word wrong"); // R10

	property p_read_hold;
		@(posedge SYS_CLK_I) disable iff (rst_q)
		(!rd_edge || ren1_n_s || ren2_n_s) |=> $stable(out_q);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("Output not held"); // R11

	property p_empty_ignore;
		@(posedge SYS_CLK_I) disable iff (rst_q)
		(rd_edge && !empty_n_q && !ofs_read) |=> ($stable(out_q) && $stable(rd_ptr_q));
	endproperty
	a_empty_ignore: assert property (p_empty_ignore) else $error("Read while empty"); // R12

	property p_empty_flags;
		@(posedge SYS_CLK_I) disable iff (rst_q)
		(rd_edge && !ofs_load) |=> (EMPTY_N_O == (arr_cnt_q != '0)
			&& ALMOST_EMPTY_N_O == (arr_cnt_q > e_ofs_x));
	endproperty
	a_empty_flags: assert property (p_empty_flags) else $error("Empty flags wrong"); // R22

	property p_afull_flag;
		@(posedge SYS_CLK_I) disable iff (rst_q)
		(wr_edge && !ofs_load) |=> ALMOST_FULL_N_O == (level_q < DEPTH_L - f_ofs_x);
	endproperty
	a_afull_flag: assert property (p_afull_flag) else $error("Almost-full wrong"); // R23

	property p_load_step;
		@(posedge SYS_CLK_I) disable iff (rst_q)
		ofs_load |=> wsel_q == sfc_ofs_next($past(wsel_q));
	endproperty
	a_load_step: assert property (p_load_step) else $error("Load order wrong"); // R19

	property p_load_keep;
		@(posedge SYS_CLK_I) disable iff (rst_q) (wr_edge && !ofs_load) |=> $stable(wsel_q);
	endproperty
	a_load_keep: assert property (p_load_keep) else $error("Load position lost"); // R20

	property p_ofs_read;
		@(posedge SYS_CLK_I) disable iff (rst_q)
		ofs_read |=> (out_q[OFS_W-1:0] == $past(ofs_rd_byte)
			&& rsel_q == sfc_ofs_next($past(rsel_q)));
	endproperty
	a_ofs_read: assert property (p_ofs_read) else $error("Offset readback wrong"); // R21

endmodule : sfc_channel

// ---- testbench/sfc_pin_partner.sv ----
// Purpose: Writer and reader logic that drive the channel's pin ports
// Assumes: Pin clocks are slow against the system clock
// Notes: The data pins show inverted data once their hold time has passed
`timescale 1ns/1ps

module sfc_pin_partner
	import sfc_pkg::*;
(
	// System
	input wire logic clk_i,
	// Write pins
	output logic wr_clk_o,
	output logic wr_en1_n_o,
	output logic wr_en2_ld_o,
	output logic [DATA_W-1:0] wr_data_o,
	// Read pins
	output logic rd_clk_o,
	output logic rd_en1_n_o,
	output logic rd_en2_n_o,
	input wire logic [DATA_W-1:0] rd_data_i
);
	int gap = 4;
	logic [DATA_W-1:0] rd_word;
	event rd_done;

	initial begin
		wr_clk_o = 1'b0;
		wr_en1_n_o = 1'b1;
		wr_en2_ld_o = 1'b0;
		wr_data_o = '0;
		rd_clk_o = 1'b0;
		rd_en1_n_o = 1'b1;
		rd_en2_n_o = 1'b1;
		rd_word = '0;
	end

	// ----------------------------------------------------------------
	// Pin cycles
	// ----------------------------------------------------------------
	task automatic mode(input logic sec);
		@(posedge clk_i);
		wr_en2_ld_o <= sec;
	endtask : mode

	// Gap sets how slowly the next cycle follows
	task automatic wr(input logic en1_n, input logic sec, input logic [DATA_W-1:0] d);
		@(posedge clk_i);
		wr_data_o <= d;
		wr_en1_n_o <= en1_n;
		wr_en2_ld_o <= sec;
		repeat (2) @(posedge clk_i);
		wr_clk_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		wr_clk_o <= 1'b0;
		wr_data_o <= ~d;
		wr_en1_n_o <= 1'b1;
		repeat (gap) @(posedge clk_i);
	endtask : wr

	// Load pin level chooses offset readback in flag mode
	task automatic rd(input logic en1_n, input logic en2_n, input logic ld);
		@(posedge clk_i);
		rd_en1_n_o <= en1_n;
		rd_en2_n_o <= en2_n;
		wr_en2_ld_o <= ld;
		repeat (2) @(posedge clk_i);
		rd_clk_o <= 1'b1;
		repeat (3) @(posedge clk_i);
		rd_clk_o <= 1'b0;
		rd_en1_n_o <= 1'b1;
		rd_en2_n_o <= 1'b1;
		repeat (gap) @(posedge clk_i);
		rd_word = rd_data_i;
		->rd_done;
	endtask : rd

endmodule : sfc_pin_partner

// ---- testbench/tb.sv ----
// Purpose: Self-checking bench for one FIFO channel
// Assumes: Small depth so fill and drain stay short
// Notes: Read results are checked against a queue of expected words
`timescale 1ns/1ps

module tb
	import sfc_pkg::*;
;
	localparam int unsigned DEPTH = 16;
	localparam logic [7:0] N_OFS = 8'h02;
	localparam logic [7:0] M_OFS = 8'h03;
	logic SYS_CLK_I = 1'b0;
	logic RST_I = 1'b0;
	logic OUTPUT_ENABLE_N_I = 1'b0;
	logic wr_clk, wr_en1_n, wr_en2_ld, rd_clk, rd_en1_n, rd_en2_n;
	logic [DATA_W-1:0] wr_data, rd_data, last;
	logic rd_oe, full_n, afull_n, empty_n, aempty_n;
	logic [31:0] lfsr_q = 32'h987d;
	logic [DATA_W-1:0] exp_q [$];
	logic [DATA_W-1:0] store_q [$];
	logic [7:0] dflt [4] = '{EMPTY_LO_RST, EMPTY_HI_RST, FULL_LO_RST, FULL_HI_RST};
	logic [7:0] newv [4] = '{N_OFS, 8'h00, M_OFS, 8'h00};
	int mismatches = 0;
	int compares = 0;
	int cyc = 0;

	always #25 SYS_CLK_I = ~SYS_CLK_I;

	sfc_channel #(.DEPTH(DEPTH), .STAGE_DEPTH(8)) u_sfc_channel (.SYS_CLK_I(SYS_CLK_I),
		.RST_I(RST_I), .WRITE_CLOCK_I(wr_clk), .WRITE_ENABLE_FIRST_N_I(wr_en1_n),
		.WRITE_ENABLE_SECOND_OR_LOAD_I(wr_en2_ld), .WRITE_DATA_I(wr_data),
		.READ_CLOCK_I(rd_clk), .READ_ENABLE_FIRST_N_I(rd_en1_n),
		.READ_ENABLE_SECOND_N_I(rd_en2_n), .OUTPUT_ENABLE_N_I(OUTPUT_ENABLE_N_I),
		.READ_DATA_O(rd_data), .READ_DATA_OE_O(rd_oe), .FULL_N_O(full_n),
		.ALMOST_FULL_N_O(afull_n), .EMPTY_N_O(empty_n), .ALMOST_EMPTY_N_O(aempty_n));

	sfc_pin_partner u_partner (.clk_i(SYS_CLK_I), .wr_clk_o(wr_clk), .wr_en1_n_o(wr_en1_n),
		.wr_en2_ld_o(wr_en2_ld), .wr_data_o(wr_data), .rd_clk_o(rd_clk),
		.rd_en1_n_o(rd_en1_n), .rd_en2_n_o(rd_en2_n), .rd_data_i(rd_data));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic final_report();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	task automatic chk_flag(input string n, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %b seen %b", n, e, g);
		end
	endtask : chk_flag

	task automatic chk_data(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk_data

	task automatic flags(input logic ef, input logic ae, input logic ff, input logic af);
		chk_flag("EMPTY_N_O", ef, empty_n);
		chk_flag("ALMOST_EMPTY_N_O", ae, aempty_n);
		chk_flag("FULL_N_O", ff, full_n);
		chk_flag("ALMOST_FULL_N_O", af, afull_n);
	endtask : flags

	task automatic rd_exp(input logic r1n, input logic r2n, input logic ld, input logic [8:0] e);
		exp_q.push_back(e);
		u_partner.rd(r1n, r2n, ld);
	endtask : rd_exp

	task automatic put(input logic [DATA_W-1:0] d);
		u_partner.wr(1'b0, 1'b1, d);
		store_q.push_back(d);
	endtask : put

	// Mode pin must settle before reset lets go
	task automatic reset_dut(input logic sec);
		u_partner.mode(sec);
		RST_I <= 1'b1;
		repeat (12) @(posedge SYS_CLK_I);
		RST_I <= 1'b0;
		repeat (4) @(posedge SYS_CLK_I);
	endtask : reset_dut

	// ----------------------------------------------------------------
	// Result watcher and timeout
	// ----------------------------------------------------------------
	initial forever begin
		@(u_partner.rd_done);
		chk_data("READ_DATA_O", exp_q.pop_front(), u_partner.rd_word);
	end

	always @(posedge SYS_CLK_I) begin
		cyc++;
		if (cyc == 30000) begin
			mismatches++;
			final_report();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		// Rise off the clock edge so every reset flop is cleared before the first sample
		#1 RST_I = 1'b1;
		reset_dut(1'b0);
		flags(1'b0, 1'b0, 1'b1, 1'b1);
		chk_data("READ_DATA_O", OUT_RST, rd_data);
		chk_flag("READ_DATA_OE_O", 1'b1, rd_oe);
		for (int i = 0; i < 4; i++) rd_exp(1'b0, 1'b0, 1'b0, {1'b0, dflt[i]});
		$display("test defaults done");
		u_partner.wr(1'b0, 1'b0, {1'b0, N_OFS});
		lfsr_q = lfsr_next(lfsr_q);
		put(lfsr_q[8:0]);
		for (int i = 1; i < 4; i++) u_partner.wr(1'b0, 1'b0, {1'b1, newv[i]});
		for (int i = 0; i < 4; i++) rd_exp(1'b0, 1'b0, 1'b0, {1'b0, newv[i]});
		flags(1'b1, 1'b0, 1'b1, 1'b1);
		u_partner.wr(1'b1, 1'b1, 9'h1ff);
		for (int k = 2; k <= DEPTH; k++) begin
			lfsr_q = lfsr_next(lfsr_q);
			put(lfsr_q[8:0]);
			chk_flag("ALMOST_FULL_N_O", !(k >= DEPTH - M_OFS), afull_n);
			chk_flag("FULL_N_O", k < DEPTH, full_n);
		end
		u_partner.wr(1'b0, 1'b1, 9'h155);
		last = 9'h000;
		rd_exp(1'b1, 1'b0, 1'b1, last);
		rd_exp(1'b0, 1'b1, 1'b1, last);
		flags(1'b1, 1'b1, 1'b0, 1'b0);
		$display("test fill done");
		u_partner.gap = 9;
		for (int r = 1; r <= DEPTH; r++) begin
			last = store_q.pop_front();
			rd_exp(1'b0, 1'b0, 1'b1, last);
			chk_flag("EMPTY_N_O", r < DEPTH, empty_n);
			chk_flag("ALMOST_EMPTY_N_O", DEPTH - r > N_OFS, aempty_n);
			if (r == 1) begin
				u_partner.wr(1'b1, 1'b1, 9'h000);
				chk_flag("FULL_N_O", 1'b1, full_n);
				chk_flag("ALMOST_FULL_N_O", 1'b0, afull_n);
			end
		end
		u_partner.gap = 4;
		rd_exp(1'b0, 1'b0, 1'b1, last);
		lfsr_q = lfsr_next(lfsr_q);
		put(lfsr_q[8:0]);
		rd_exp(1'b1, 1'b1, 1'b1, last);
		flags(1'b1, 1'b0, 1'b1, 1'b1);
		last = store_q.pop_front();
		rd_exp(1'b0, 1'b0, 1'b1, last);
		$display("test drain done");
		@(posedge SYS_CLK_I) OUTPUT_ENABLE_N_I <= 1'b1;
		repeat (3) @(posedge SYS_CLK_I);
		chk_flag("READ_DATA_OE_O", 1'b0, rd_oe);
		OUTPUT_ENABLE_N_I <= 1'b0;
		repeat (3) @(posedge SYS_CLK_I);
		chk_flag("READ_DATA_OE_O", 1'b1, rd_oe);
		$display("test output enable done");
		put(9'h0aa);
		store_q.delete();
		reset_dut(1'b1);
		flags(1'b0, 1'b0, 1'b1, 1'b1);
		chk_data("READ_DATA_O", OUT_RST, rd_data);
		u_partner.wr(1'b0, 1'b0, 9'h0aa);
		u_partner.wr(1'b1, 1'b1, 9'h0bb);
		put(9'h1cc);
		rd_exp(1'b1, 1'b1, 1'b0, 9'h000);
		chk_flag("EMPTY_N_O", 1'b1, empty_n);
		rd_exp(1'b0, 1'b0, 1'b0, 9'h1cc);
		rd_exp(1'b0, 1'b0, 1'b0, 9'h1cc);
		chk_flag("EMPTY_N_O", 1'b0, empty_n);
		$display("test two enables done");
		final_report();
	end

endmodule : tb
